/* File: rtl/relay_mux_pkg.sv */
//------------------------------------------------------------------
// shared constants and types of the relay command decoder
//------------------------------------------------------------------
package relay_mux_pkg;

   // register numbers on the backplane address lines
   localparam int REG_NUM_W = 3;
   localparam logic [2:0] REG_CARD_RESET = 3'h0; // card_reset_trigger
   localparam logic [2:0] REG_OPEN = 3'h3; // relay_open_command
   localparam logic [2:0] REG_CLOSE = 3'h6; // relay_close_command

   // backplane data width and command word width
   localparam int DATA_W = 16;
   localparam int CMD_W = 15;

   // command word field positions
   localparam int TREE_EN_BIT = 14;
   localparam int BANK_B_EN_BIT = 13;
   localparam int BANK_A_EN_BIT = 12;
   localparam int TREE_LSB = 8;
   localparam int BANK_B_LSB = 4;
   localparam int BANK_A_LSB = 0;

   // tree relay positions inside the four-bit tree field
   localparam int TREE_RELAY_BIT11 = 3;
   localparam int TREE_RELAY_BIT10 = 2;
   localparam int TREE_RELAY_BIT9 = 1;
   localparam int TREE_RELAY_BIT8 = 0;

   // bank code values: no channel closed, highest decimal digit
   localparam logic [3:0] BANK_IDLE = 4'hc;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [3:0] TREE_ALL_OPEN = 4'h0;
   localparam int BANK_CH = 10;

   // timing
   localparam real CLK_PERIOD_NS = 50.0;
   localparam real STROBE_PULSE_US = 100.0;
   localparam real RELAY_SETTLE_MS = 1.1;
   localparam int STROBE_CYC = int'($ceil(STROBE_PULSE_US * 1000.0 / CLK_PERIOD_NS));
   localparam int SETTLE_CYC = int'($ceil(RELAY_SETTLE_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int TIMER_W = 16;

   // command word as it arrives on the data lines
   typedef struct packed {
      logic spare;
      logic tree_en;
      logic bank_b_en;
      logic bank_a_en;
      logic [3:0] tree;
      logic [3:0] bank_b;
      logic [3:0] bank_a;
   } cmd_word_t;

   // relay state, also the layout of the status readback
   typedef struct packed {
      logic [3:0] tree;
      logic [3:0] bank_b;
      logic [3:0] bank_a;
   } relay_state_t;

   localparam relay_state_t RELAYS_RESET = {TREE_ALL_OPEN, BANK_IDLE, BANK_IDLE};

   // sequencing of one command
   typedef enum logic [2:0] {
      IDLE,
      OPEN_PULSE,
      CLOSE_WAIT,
      CLOSE_PULSE,
      SETTLE
   } seq_state_t;

endpackage : relay_mux_pkg

/* File: rtl/relay_mux_command_decoder.sv */
// How it works
// - reset-register write opens every relay
// - reset-register write aborts any pending sequence
// - all three resets give identical end state
// - open write pulses opening strobe, opens relays
// - close write pulses closing strobe, closes relays
// - closures wait until opening strobe ends
// - command word is fifteen bits, four fields
// - register number alone picks open or close
// - bits 14,13,12 enable tree, B, A
// - disabled groups stay untouched
// - any enable combination works in one write
// - tree bits 11 to 8 drive tree relays
// - bank A nibble is a BCD channel
// - bank nibbles decoded independently, when enabled
// - bank B code n selects channel 10+n
// - busy flag while a command executes
// - status readback updates after relays settle
`timescale 1ns/100ps
`default_nettype none

module relay_mux_command_decoder #(
   parameter int SETTLE_CYCLES = relay_mux_pkg::SETTLE_CYC
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // backplane write cycle and resets
   input wire logic [relay_mux_pkg::REG_NUM_W-1:0] bp_addr,
   input wire logic [relay_mux_pkg::DATA_W-1:0] bp_data,
   input wire logic bp_write_b,
   input wire logic bp_reset_b,
   input wire logic slot_reset_b,
   // shared opening strobe line, open drain
   input wire logic opening_in,
   output logic opening_out,
   output logic opening_oe,
   // closing strobe line, open drain
   output logic closing_out,
   output logic closing_oe,
   // relay drive
   output var relay_mux_pkg::relay_state_t relays,
   output logic [relay_mux_pkg::BANK_CH-1:0] bank_a_relay,
   output logic [relay_mux_pkg::BANK_CH-1:0] bank_b_relay,
   // readable status
   output logic busy,
   output var relay_mux_pkg::relay_state_t relay_status
);
   import relay_mux_pkg::*;

   // refuse timer counts that the shared counter cannot hold
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << TIMER_W)
       || STROBE_CYC < 1 || STROBE_CYC >= (1 << TIMER_W)) begin : g_bad_timer
      $error("relay_mux_command_decoder: timer counts out of range");
   end

   //---------------------------------------------------------------
   // functions
   //---------------------------------------------------------------

   // one-hot relay drive of a BCD code, none for idle or illegal codes
   function automatic logic [BANK_CH-1:0] bcd_one_hot(input logic [3:0] code);
      logic [BANK_CH-1:0] hot;
      hot = '0;
      if (code <= BCD_MAX) begin
         hot[code] = 1'b1;
      end
      return hot;
   endfunction : bcd_one_hot

   // next code of one bank for an enabled open or close
   function automatic logic [3:0] bank_next(input logic [3:0] cur, input logic [3:0] sel,
                                            input logic en, input logic close);
      logic [3:0] nxt;
      nxt = cur;
      if (en && sel <= BCD_MAX) begin
         if (close) begin
            nxt = sel;
         end else if (cur == sel) begin
            nxt = BANK_IDLE;
         end
      end
      return nxt;
   endfunction : bank_next

   // whole command word applied to the relay state
   function automatic relay_state_t apply_word(input relay_state_t cur, input cmd_word_t cmd,
                                               input logic close);
      relay_state_t nxt;
      nxt = cur;
      if (cmd.tree_en) begin
         nxt.tree = close ? (cur.tree | cmd.tree) : (cur.tree & ~cmd.tree);
      end
      // every group checked on its own, so any mix of enables acts at once
      nxt.bank_a = bank_next(cur.bank_a, cmd.bank_a, cmd.bank_a_en, close);
      nxt.bank_b = bank_next(cur.bank_b, cmd.bank_b, cmd.bank_b_en, close);
      return nxt;
   endfunction : apply_word

   //---------------------------------------------------------------
   // backplane synchronisers
   //---------------------------------------------------------------

   logic wr_b_s1, wr_b_s2, wr_b_s3;
   logic bpr_s1, bpr_s2, slr_s1, slr_s2;
   logic open_s1, open_s2;
   logic [REG_NUM_W-1:0] addr_s1, addr_s2;
   logic [DATA_W-1:0] data_s1, data_s2;

   // two flops on every pin, a third on the write strobe for its edge
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_b_s1 <= 1'b1;
         wr_b_s2 <= 1'b1;
         wr_b_s3 <= 1'b1;
         bpr_s1 <= 1'b1;
         bpr_s2 <= 1'b1;
         slr_s1 <= 1'b1;
         slr_s2 <= 1'b1;
         open_s1 <= 1'b0;
         open_s2 <= 1'b0;
         addr_s1 <= '0;
         addr_s2 <= '0;
         data_s1 <= '0;
         data_s2 <= '0;
      end else if (ce) begin
         wr_b_s1 <= bp_write_b;
         wr_b_s2 <= wr_b_s1;
         wr_b_s3 <= wr_b_s2;
         bpr_s1 <= bp_reset_b;
         bpr_s2 <= bpr_s1;
         slr_s1 <= slot_reset_b;
         slr_s2 <= slr_s1;
         open_s1 <= opening_in;
         open_s2 <= open_s1;
         addr_s1 <= bp_addr;
         addr_s2 <= addr_s1;
         data_s1 <= bp_data;
         data_s2 <= data_s1;
      end
   end

   //---------------------------------------------------------------
   // write decode
   //---------------------------------------------------------------

   logic wr_fall, wr_reset, card_clear, accept, acc_open, acc_close;
   cmd_word_t cmd, pend;
   seq_state_t state, next_state;
   logic [TIMER_W-1:0] timer;

   // the write is taken on the falling edge of the synced strobe
   assign wr_fall = !wr_b_s2 && wr_b_s3;
   assign wr_reset = wr_fall && (addr_s2 == REG_CARD_RESET);
   // one clear for reset write, backplane reset and slot reset
   assign card_clear = wr_reset || !bpr_s2 || !slr_s2;
   // a command while busy is dropped; pacing is up to the controller
   assign accept = wr_fall && (state == IDLE) && !card_clear;
   assign acc_open = accept && (addr_s2 == REG_OPEN);
   assign acc_close = accept && (addr_s2 == REG_CLOSE);
   // bit 15 is carried but never read
   assign cmd = cmd_word_t'(data_s2);

   // pending close word held until the opening strobe is gone
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pend <= '0;
      end else if (ce) begin
         if (acc_close) begin
            pend <= cmd;
         end
      end
   end

   //---------------------------------------------------------------
   // sequencer
   //---------------------------------------------------------------

   // next sequence state
   always_comb begin
      next_state = state;
      unique case (state)
         IDLE: begin
            if (acc_open) begin
               next_state = OPEN_PULSE;
            end else if (acc_close) begin
               next_state = CLOSE_WAIT;
            end
         end
         OPEN_PULSE: begin
            if (timer == '0) begin
               next_state = SETTLE;
            end
         end
         CLOSE_WAIT: begin
            if (!open_s2) begin
               next_state = CLOSE_PULSE;
            end
         end
         CLOSE_PULSE: begin
            if (timer == '0) begin
               next_state = SETTLE;
            end
         end
         SETTLE: begin
            if (timer == '0) begin
               next_state = IDLE;
            end
         end
      endcase
      if (card_clear) begin
         next_state = IDLE;
      end
   end

   // state register and the one timer shared by pulse and settle
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= IDLE;
         timer <= '0;
      end else if (ce) begin
         state <= next_state;
         if (next_state != state) begin
            if (next_state == SETTLE) begin
               timer <= TIMER_W'(SETTLE_CYCLES - 1);
            end else begin
               timer <= TIMER_W'(STROBE_CYC - 1);
            end
         end else if (timer != '0) begin
            timer <= timer - 1'b1;
         end
      end
   end

   // strobes and busy flag, all registered
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         opening_out <= 1'b0;
         opening_oe <= 1'b0;
         closing_out <= 1'b0;
         closing_oe <= 1'b0;
         busy <= 1'b0;
      end else if (ce) begin
         opening_out <= 1'b0;
         closing_out <= 1'b0;
         opening_oe <= (next_state == OPEN_PULSE);
         closing_oe <= (next_state == CLOSE_PULSE);
         busy <= (next_state != IDLE);
      end
   end

   //---------------------------------------------------------------
   // relay state
   //---------------------------------------------------------------

   relay_state_t next_relays;

   // opens act at once, closures only on entering the closing pulse
   always_comb begin
      next_relays = relays;
      if (card_clear) begin
         next_relays = RELAYS_RESET;
      end else if (acc_open) begin
         next_relays = apply_word(relays, cmd, 1'b0);
      end else if (state == CLOSE_WAIT && !open_s2) begin
         next_relays = apply_word(relays, pend, 1'b1);
      end
   end

   // relay codes and their one-hot drives move together
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         relays <= RELAYS_RESET;
         bank_a_relay <= '0;
         bank_b_relay <= '0;
      end else if (ce) begin
         relays <= next_relays;
         bank_a_relay <= bcd_one_hot(next_relays.bank_a);
         bank_b_relay <= bcd_one_hot(next_relays.bank_b);
      end
   end

   // readback copies the relays only once the settle time has run out
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         relay_status <= RELAYS_RESET;
      end else if (ce) begin
         if (card_clear) begin
            relay_status <= RELAYS_RESET;
         end else if (state == SETTLE && timer == '0) begin
            relay_status <= relays;
         end
      end
   end

   //---------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------

   sequence s_close_req;
      acc_close ##1 (!open_s2 && !card_clear);
   endsequence

   sequence s_close_held;
      (state == CLOSE_WAIT) && open_s2 && !card_clear;
   endsequence

   a_reset_opens_all: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      card_clear |=> (relays == RELAYS_RESET) && (bank_a_relay == '0) && (bank_b_relay == '0))
      else $error("relays not all open after clear");

   a_reset_aborts_seq: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      card_clear |=> (state == IDLE) && !busy && !opening_oe && !closing_oe)
      else $error("sequence survived a clear");

   a_slot_reset_same: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      (!slr_s2 || !bpr_s2) |=> (relays == RELAYS_RESET) && (relay_status == RELAYS_RESET)
      && !busy)
      else $error("pin reset differs from reset write");

   a_open_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      acc_open |=> opening_oe && busy && !closing_oe)
      else $error("open write gave no opening strobe");

   a_close_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      s_close_req |=> closing_oe)
      else $error("close write gave no closing strobe");

   a_close_deferred: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      s_close_held |=> !closing_oe && $stable(relays))
      else $error("closure during opening strobe");

   a_mask_gates: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      (acc_open && !cmd.bank_a_en) |=> $stable(relays.bank_a))
      else $error("disabled bank A changed");

   a_bank_b_close: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      ($rose(closing_oe) && pend.bank_b_en && pend.bank_b <= BCD_MAX)
      |-> (relays.bank_b == pend.bank_b) && (bank_b_relay == bcd_one_hot(pend.bank_b)))
      else $error("bank B closure wrong");

   a_busy_flag: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      (acc_open || acc_close) |=> busy ##1 (busy || $past(card_clear)))
      else $error("busy not set by command");

   a_status_late: assert property (@(posedge sys_clk) disable iff (!rst_b || !ce)
      $changed(relay_status) |-> ($past(state) == SETTLE) || $past(card_clear))
      else $error("status changed before settle");

endmodule : relay_mux_command_decoder

`default_nettype wire

/* File: testbench/relay_mux_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// controller model: drives backplane write cycles
// ----------------------------------------------------------------
module relay_mux_host_model #(
   parameter int GAP_CYC = 44445
) (
   // clock
   input wire logic sys_clk,
   // card status
   input wire logic busy,
   // backplane write pins
   output logic [relay_mux_pkg::REG_NUM_W-1:0] bp_addr,
   output logic [relay_mux_pkg::DATA_W-1:0] bp_data,
   output logic bp_write_b
);
   import relay_mux_pkg::*;
   int cyc = 0;
   int last_cmd = -1000000;

   // idle levels at time zero
   initial begin
      bp_addr = 3'h7;
      bp_data = 16'hffff;
      bp_write_b = 1'b1;
   end

   // free cycle count for command spacing
   always @(posedge sys_clk) cyc <= cyc + 1;

   // one write cycle; commands wait for idle card and rate spacing
   task automatic write_reg(input logic [2:0] addr, input logic [15:0] data,
                            output logic ok);
      int n;
      n = 0;
      if (addr != REG_CARD_RESET) begin
         while ((busy !== 1'b0 || cyc - last_cmd < GAP_CYC) && n < 5000) begin
            @(posedge sys_clk);
            n++;
         end
         last_cmd = cyc;
      end
      ok = (n < 5000);
      @(posedge sys_clk);
      bp_addr <= addr;
      bp_data <= data;
      @(posedge sys_clk);
      bp_write_b <= 1'b0;
      repeat (6) @(posedge sys_clk);
      bp_write_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // released lines show no stale value
      bp_addr <= ~addr;
      bp_data <= ~data;
   endtask : write_reg
endmodule : relay_mux_host_model

`default_nettype wire

/* File: testbench/relay_mux_command_decoder_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module relay_mux_command_decoder_bench;
   import relay_mux_pkg::*;
   localparam int SETTLE_SIM = 20;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic bp_reset_b = 1'b1;
   logic slot_reset_b = 1'b1;
   logic other_open = 1'b0;
   logic [REG_NUM_W-1:0] bp_addr;
   logic [DATA_W-1:0] bp_data;
   logic bp_write_b, opening_in, opening_out, opening_oe, closing_out, closing_oe, busy;
   relay_state_t relays, relay_status, cur;
   logic [BANK_CH-1:0] bank_a_relay, bank_b_relay;
   int miscompares = 0;
   int samples_checked = 0;
   int run_len = 0;
   int last_len = 0;

   // ----------------------------------------------------------------
   // clock, shared opening line, instances
   // ----------------------------------------------------------------
   initial forever #25 sys_clk = ~sys_clk;
   assign opening_in = opening_oe | other_open;

   relay_mux_command_decoder #(.SETTLE_CYCLES(SETTLE_SIM)) u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .bp_addr(bp_addr), .bp_data(bp_data),
      .bp_write_b(bp_write_b), .bp_reset_b(bp_reset_b), .slot_reset_b(slot_reset_b),
      .opening_in(opening_in), .opening_out(opening_out), .opening_oe(opening_oe),
      .closing_out(closing_out), .closing_oe(closing_oe), .relays(relays),
      .bank_a_relay(bank_a_relay), .bank_b_relay(bank_b_relay), .busy(busy),
      .relay_status(relay_status));

   relay_mux_host_model #(.GAP_CYC(30)) u_host (
      .sys_clk(sys_clk), .busy(busy), .bp_addr(bp_addr), .bp_data(bp_data),
      .bp_write_b(bp_write_b));

   // width of the last strobe pulse
   always @(posedge sys_clk) begin
      if (opening_oe | closing_oe) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         last_len <= run_len;
         run_len <= 0;
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one cycle of a bounded wait
   task automatic tick(inout int n);
      @(posedge sys_clk);
      n++;
      if (n > 5000) begin
         $display("[ERR] %0t wait limit reached", $time);
         miscompares++;
         finish_test();
      end
   endtask : tick

   function automatic logic [15:0] hot(input logic [3:0] code);
      return (code > BCD_MAX) ? 16'h0 : 16'(16'h1 << code);
   endfunction : hot

   task automatic check_clear();
      check(16'(relays), 16'h00cc);
      check(16'(relay_status), 16'h00cc);
      check(16'(bank_a_relay | bank_b_relay), 16'h0);
      check(16'({busy, opening_oe, closing_oe, opening_out, closing_out}), 16'h0);
      cur = 12'h0cc;
   endtask : check_clear

   task automatic issue(input logic [2:0] addr, input logic [15:0] data);
      logic ok;
      u_host.write_reg(addr, data, ok);
      #1;
      check(16'(ok), 16'h1);
      if (ok !== 1'b1) begin
         finish_test();
      end
      check(16'(busy), 16'h1);
   endtask : issue

   // follow a running command to its end and judge it
   task automatic finish_cmd(input logic [2:0] addr, input relay_state_t exp);
      int n;
      n = 0;
      while ((opening_oe | closing_oe) !== 1'b1) tick(n);
      #1;
      check(16'(opening_oe), 16'(addr == REG_OPEN));
      check(16'(closing_oe), 16'(addr == REG_CLOSE));
      check(16'(relay_status), 16'(cur));
      check(16'(relays), 16'(exp));
      check(16'(bank_a_relay), hot(exp.bank_a));
      check(16'(bank_b_relay), hot(exp.bank_b));
      while (busy !== 1'b0) tick(n);
      #1;
      check(16'(last_len), 16'(STROBE_CYC));
      check(16'(relay_status), 16'(exp));
      cur = exp;
   endtask : finish_cmd

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic do_cmd(input logic [2:0] addr, input logic [15:0] data,
                         input relay_state_t exp);
      issue(addr, data);
      finish_cmd(addr, exp);
   endtask : do_cmd

   // closures held off while another card's opening strobe runs
   task automatic deferred_close();
      @(posedge sys_clk);
      other_open <= 1'b1;
      issue(REG_CLOSE, 16'h1009);
      repeat (40) @(posedge sys_clk);
      #1;
      check(16'(closing_oe), 16'h0);
      check(16'(relays), 16'(cur));
      @(posedge sys_clk);
      other_open <= 1'b0;
      finish_cmd(REG_CLOSE, {4'h4, 4'h0, 4'h9});
   endtask : deferred_close

   // each clear kind aborts a close in mid-strobe
   task automatic abort_by_clear(input int kind);
      int n;
      logic ok;
      n = 0;
      issue(REG_CLOSE, 16'h4b00);
      while (closing_oe !== 1'b1) tick(n);
      if (kind == 0) begin
         u_host.write_reg(REG_CARD_RESET, 16'h1234, ok);
      end else begin
         @(posedge sys_clk);
         bp_reset_b <= (kind != 1);
         slot_reset_b <= (kind != 2);
         repeat (4) @(posedge sys_clk);
         bp_reset_b <= 1'b1;
         slot_reset_b <= 1'b1;
         repeat (6) @(posedge sys_clk);
      end
      #1;
      check_clear();
      repeat (30) @(posedge sys_clk);
      #1;
      check_clear();
   endtask : abort_by_clear

   // a write with the clock enable low and one to an unused register change nothing
   task automatic ignored_writes();
      logic ok;
      @(posedge sys_clk);
      ce <= 1'b0;
      u_host.write_reg(REG_CLOSE, 16'h7573, ok);
      ce <= 1'b1;
      u_host.write_reg(3'h4, 16'h7fff, ok);
      #1;
      check(16'(busy), 16'h0);
      check(16'(relays), 16'(cur));
      check(16'(closing_oe | opening_oe), 16'h0);
   endtask : ignored_writes

   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1;
      check_clear();
      do_cmd(REG_CLOSE, 16'h7573, {4'h5, 4'h7, 4'h3});
      do_cmd(REG_OPEN, 16'hc173, {4'h4, 4'h7, 4'h3});
      do_cmd(REG_CLOSE, 16'h2f09, {4'h4, 4'h0, 4'h3});
      deferred_close();
      do_cmd(REG_OPEN, 16'h3009, {4'h4, 4'hc, 4'hc});
      do_cmd(REG_CLOSE, 16'h30f2, {4'h4, 4'hc, 4'h2});
      ignored_writes();
      for (int k = 0; k < 3; k++) begin
         abort_by_clear(k);
      end
      finish_test();
   end
endmodule : relay_mux_command_decoder_bench

`default_nettype wire
